// *** hdl/cct_defines.svh ***
`ifndef CCT_DEFINES_SVH
`define CCT_DEFINES_SVH

// Register byte offsets
`define CCT_OFS_CTRL 12'h000
`define CCT_OFS_COUNT 12'h004
`define CCT_OFS_MODULO 12'h008
`define CCT_OFS_CH0_CTRL 12'h00c
`define CCT_OFS_CH0_VAL 12'h010
`define CCT_OFS_CH1_CTRL 12'h014
`define CCT_OFS_CH1_VAL 12'h018

// Timer control field positions
`define CCT_CTRL_PS_LO 0
`define CCT_CTRL_RST 4
`define CCT_CTRL_HALT 5
`define CCT_CTRL_OVIE 6
`define CCT_CTRL_OVF 7

// Channel control field positions
`define CCT_CH_ELS_LO 0
`define CCT_CH_ELS_HI 1
`define CCT_CH_TOV 2
`define CCT_CH_MODE 3
`define CCT_CH_LINK 4
`define CCT_CH_IE 6
`define CCT_CH_FLAG 7

// Reset values
`define CCT_CTRL_RESET 8'h20
`define CCT_MOD_RESET 16'hffff
`define CCT_CH_RESET 8'h00

// Capture pipeline depth in bus cycles
`define CCT_CAP_DELAY 2

`endif

// *** hdl/cct_pkg.sv ***
package cct_pkg;

    // Channel control fields
    typedef struct packed {
        logic flag;
        logic ie;
        logic unused;
        logic link;
        logic mode;
        logic tov;
        logic els_hi;
        logic els_lo;
    } cct_chctl_t;

    // Timer control fields
    typedef struct packed {
        logic ovf;
        logic ovie;
        logic halt;
        logic rst;
        logic unused;
        logic [2:0] ps;
    } cct_ctl_t;

    // Pin group
    typedef struct packed {
        logic [1:0] o;
        logic [1:0] oe;
    } cct_pins_t;

endpackage

// *** hdl/cct_timer.sv ***
// Behaviour
// - 16-bit up-counter, free or modulo
// - counter reads never disturb counting
// - each channel independently capture or compare
// - seven prescaler rates from bus clock
// - selected pin edge captures counter value
// - every edge overwrites capture, flag ignored
// - capture lands two bus cycles after edge
// - capture sets flag, enable raises interrupt
// - reset leaves capture registers untouched
// - compare match sets, clears or toggles pin
// - compare match sets flag, may interrupt
// - optional per-channel toggle on overflow
// - counter stop and reset controls exist
// - link bit joins channels onto pin 0
// - last written pair takes over at overflow
// - linked, channel 1 control is ignored
// - linked, channel 1 pin released
// - overflow flag at modulo, optional interrupt
// - stop halts counter, reset clears prescaler
//
// The APB interface to the registers and the placing of the registers were decided locally.
`include "cct_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cct_timer
    import cct_pkg::*;
#(
    parameter int CW = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Channel pins
    input wire logic [1:0] chan_pin_in,
    output logic [1:0] chan_pin_out,
    output logic [1:0] chan_pin_oe,
    // Interrupt request
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        cct_ctl_t ctl;
        logic [CW-1:0] cnt;
        logic [CW-1:0] modv;
        logic [6:0] pre;
        cct_chctl_t [1:0] chc;
        logic [1:0] pin_d;
        logic [1:0] cap_p1;
        logic [1:0][CW-1:0] cap_v1;
        logic [1:0] pin_o;
        logic [1:0] oe;
        logic act1;
        logic pend1;
        logic [31:0] rd;
        logic rdy;
        logic err;
        logic irq;
    } cct_state_t;

    cct_state_t s_r;
    cct_state_t s_nxt;
    logic [1:0][CW-1:0] val_r;
    logic [1:0][CW-1:0] val_nxt;
    logic [1:0] val_we;

    logic acc;
    logic wr;
    logic tick;
    logic ovf_hit;
    logic [1:0] edge_hit;
    logic [1:0] cmp_hit;
    logic [1:0] is_cmp;
    logic [CW-1:0] cmp0;
    logic [6:0] pre_inc;
    cct_chctl_t [1:0] chc_w;

    assign acc = psel && penable && !s_r.rdy;
    assign wr = acc && pwrite;
    assign pre_inc = s_r.pre + 7'h01;

    ////////////////////////////////////////////////////////////////////////
    // Counter clock: tick on the carry out of prescaler bit ps-1
    always_comb begin
        if (s_r.ctl.halt) begin
            tick = 1'b0;
        end else if (s_r.ctl.ps == 3'h0) begin
            tick = 1'b1;
        end else if (s_r.ctl.ps == 3'h7) begin
            tick = 1'b0; // Unused code: counter holds
        end else begin
            tick = &(s_r.pre | ~((7'h01 << s_r.ctl.ps) - 7'h01)) ||
                (s_r.pre[5:0] & ((6'h01 << s_r.ctl.ps) - 6'h01)) ==
                ((6'h01 << s_r.ctl.ps) - 6'h01);
        end
    end

    // Overflow when count meets modulo; all-ones modulo is free running
    assign ovf_hit = tick && (s_r.cnt == s_r.modv);

    // Linked mode: channel 0 compares against the active pair
    assign cmp0 = (s_r.chc[0].link && s_r.act1) ? val_r[1] : val_r[0];

    ////////////////////////////////////////////////////////////////////////
    // Per-channel edge detection and compare
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            // Channel 1 gets no function while linked
            assign is_cmp[g] = (g == 0) ? (s_r.chc[0].mode || s_r.chc[0].link) :
                (s_r.chc[1].mode && !s_r.chc[0].link);
            assign edge_hit[g] = !is_cmp[g] && !(g == 1 && s_r.chc[0].link) &&
                ((s_r.chc[g].els_lo && !s_r.pin_d[g] && chan_pin_in[g]) ||
                 (s_r.chc[g].els_hi && s_r.pin_d[g] && !chan_pin_in[g]));
            assign cmp_hit[g] = is_cmp[g] && tick &&
                (s_r.cnt == ((g == 0) ? cmp0 : val_r[1]));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Channel control write image, shared by the write path below
    always_comb begin
        chc_w[0] = cct_chctl_t'(pwdata[7:0]);
        chc_w[1] = cct_chctl_t'(pwdata[7:0]);
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_nxt = s_r;
        val_nxt = val_r;
        val_we = 2'b00;
        s_nxt.rdy = acc;
        s_nxt.err = 1'b0;
        s_nxt.pin_d = chan_pin_in;
        // Prescaler; reset control clears it and self-clears
        if (s_r.ctl.rst) begin
            s_nxt.pre = 7'h00;
            s_nxt.cnt = '0;
            s_nxt.ctl.rst = 1'b0;
        end else if (!s_r.ctl.halt) begin
            s_nxt.pre = pre_inc;
        end
        // Counter, reads never touch it
        if (!s_r.ctl.rst && tick) begin
            s_nxt.cnt = ovf_hit ? '0 : s_r.cnt + 1'b1;
        end
        // Capture pipeline: stage then commit, two cycles after the pin edge
        s_nxt.cap_p1 = edge_hit;
        for (int i = 0; i < 2; i++) begin
            if (edge_hit[i]) begin
                s_nxt.cap_v1[i] = s_r.cnt;
            end
            if (s_r.cap_p1[i]) begin
                val_nxt[i] = s_r.cap_v1[i];
                val_we[i] = 1'b1;
            end
        end
        // Buffer hand-over at overflow
        if (ovf_hit && s_r.chc[0].link) begin
            s_nxt.act1 = s_r.pend1;
        end
        // Pin actions: compare action, then overflow toggle
        for (int i = 0; i < 2; i++) begin
            if (cmp_hit[i]) begin
                case ({s_r.chc[i].els_hi, s_r.chc[i].els_lo})
                    2'b01: s_nxt.pin_o[i] = ~s_r.pin_o[i];
                    2'b10: s_nxt.pin_o[i] = 1'b0;
                    2'b11: s_nxt.pin_o[i] = 1'b1;
                    default: s_nxt.pin_o[i] = s_r.pin_o[i];
                endcase
            end
            if (ovf_hit && is_cmp[i] && s_r.chc[i].tov) begin
                s_nxt.pin_o[i] = ~s_nxt.pin_o[i];
            end
        end
        // Register writes
        if (wr) begin
            if (paddr == `CCT_OFS_CTRL) begin
                s_nxt.ctl.ps = pwdata[`CCT_CTRL_PS_LO +: 3];
                s_nxt.ctl.rst = pwdata[`CCT_CTRL_RST];
                s_nxt.ctl.halt = pwdata[`CCT_CTRL_HALT];
                s_nxt.ctl.ovie = pwdata[`CCT_CTRL_OVIE];
                if (!pwdata[`CCT_CTRL_OVF]) begin
                    s_nxt.ctl.ovf = 1'b0; // Write zero clears
                end
            end else if (paddr == `CCT_OFS_MODULO) begin
                s_nxt.modv = pwdata[CW-1:0];
            end else if (paddr == `CCT_OFS_CH0_CTRL || paddr == `CCT_OFS_CH1_CTRL) begin
                for (int i = 0; i < 2; i++) begin
                    if (paddr == ((i == 0) ? `CCT_OFS_CH0_CTRL : `CCT_OFS_CH1_CTRL)) begin
                        s_nxt.chc[i].els_lo = chc_w[i].els_lo;
                        s_nxt.chc[i].els_hi = chc_w[i].els_hi;
                        s_nxt.chc[i].tov = chc_w[i].tov;
                        s_nxt.chc[i].mode = chc_w[i].mode;
                        s_nxt.chc[i].link = (i == 0) ? chc_w[i].link : 1'b0;
                        s_nxt.chc[i].ie = chc_w[i].ie;
                        if (!chc_w[i].flag) begin
                            s_nxt.chc[i].flag = 1'b0;
                        end
                    end
                end
                if (paddr == `CCT_OFS_CH0_CTRL && chc_w[0].link && !s_r.chc[0].link) begin
                    s_nxt.act1 = 1'b0; // Channel 0 pair starts in control
                    s_nxt.pend1 = 1'b0;
                end
            end else if (paddr == `CCT_OFS_CH0_VAL) begin
                val_nxt[0] = pwdata[CW-1:0];
                val_we[0] = 1'b1;
                s_nxt.pend1 = 1'b0;
            end else if (paddr == `CCT_OFS_CH1_VAL) begin
                val_nxt[1] = pwdata[CW-1:0];
                val_we[1] = 1'b1;
                s_nxt.pend1 = 1'b1;
            end else if (paddr != `CCT_OFS_COUNT) begin
                s_nxt.err = 1'b1;
            end
        end
        // Flags: hardware set wins over software clear
        if (ovf_hit) begin
            s_nxt.ctl.ovf = 1'b1;
        end
        for (int i = 0; i < 2; i++) begin
            if (s_r.cap_p1[i] || cmp_hit[i]) begin
                s_nxt.chc[i].flag = 1'b1;
            end
        end
        // Read data
        s_nxt.rd = 32'h0000_0000;
        if (acc && !pwrite) begin
            if (paddr == `CCT_OFS_CTRL) begin
                s_nxt.rd = {24'h000000, s_r.ctl};
            end else if (paddr == `CCT_OFS_COUNT) begin
                s_nxt.rd = {16'h0000, s_r.cnt};
            end else if (paddr == `CCT_OFS_MODULO) begin
                s_nxt.rd = {16'h0000, s_r.modv};
            end else if (paddr == `CCT_OFS_CH0_CTRL) begin
                s_nxt.rd = {24'h000000, s_r.chc[0]};
            end else if (paddr == `CCT_OFS_CH0_VAL) begin
                s_nxt.rd = {16'h0000, val_r[0]};
            end else if (paddr == `CCT_OFS_CH1_CTRL) begin
                s_nxt.rd = {24'h000000, s_r.chc[1]};
            end else if (paddr == `CCT_OFS_CH1_VAL) begin
                s_nxt.rd = {16'h0000, val_r[1]};
            end else begin
                s_nxt.err = 1'b1;
            end
        end
        // Interrupt request
        s_nxt.irq = (s_nxt.ctl.ovf && s_nxt.ctl.ovie) ||
            (s_nxt.chc[0].flag && s_nxt.chc[0].ie) ||
            (s_nxt.chc[1].flag && s_nxt.chc[1].ie);
        // Pin drive enables, registered from the next config so they track writes
        s_nxt.oe[0] = s_nxt.chc[0].mode || s_nxt.chc[0].link;
        s_nxt.oe[1] = s_nxt.chc[1].mode && !s_nxt.chc[0].link;
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and status flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.ctl <= cct_ctl_t'(`CCT_CTRL_RESET);
            s_r.modv <= `CCT_MOD_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Channel value pairs have no reset so captured times survive it
    generate
        for (g = 0; g < 2; g++) begin : g_val
            always_ff @(posedge pclk) begin
                if (val_we[g]) begin
                    val_r[g] <= val_nxt[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata = s_r.rd;
    assign pready = s_r.rdy;
    assign pslverr = s_r.err;
    assign irq = s_r.irq;
    assign chan_pin_out = s_r.pin_o;
    // Linked, pin 1 goes back to general-purpose use
    assign chan_pin_oe = s_r.oe;

endmodule

`default_nettype wire

// *** testbench/cct_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module cct_pin_model (
    // Clock
    input wire logic pclk,
    // Far side wish and timer drive
    input wire logic [1:0] want,
    input wire logic [1:0] oe,
    input wire logic [1:0] drv,
    // Wire level
    output logic [1:0] pin
);
    logic [1:0] lvl_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Edges land just after a clock edge; a pin the timer drives reads its own level
    always_ff @(posedge pclk) begin
        for (int i = 0; i < 2; i++) begin
            lvl_r[i] <= oe[i] ? drv[i] : want[i];
        end
    end
    assign pin = lvl_r;
endmodule

`default_nettype wire

// *** testbench/cct_timer_monitor.sv ***
`include "cct_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cct_timer_monitor #(
    parameter int CW = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and interrupt
    input wire logic [1:0] chan_pin_oe,
    input wire logic irq
);
    logic done_w, busy0, link_r, m0_r, halt_r, seen_r;
    logic [2:0] en_r;
    logic [15:0] cnt_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of config; busy0 masks the cycles where the design may update first
    assign done_w = psel && penable && pready;
    assign busy0 = psel && pwrite && paddr == `CCT_OFS_CH0_CTRL;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {link_r, m0_r, seen_r, en_r, cnt_r} <= '0;
            halt_r <= 1'b1;
        end else if (done_w && pwrite) begin
            if (paddr == `CCT_OFS_CTRL) begin
                {en_r[0], halt_r, seen_r} <= {pwdata[6], pwdata[5], 1'b0};
            end
            if (paddr == `CCT_OFS_CH0_CTRL) begin
                {en_r[1], link_r, m0_r} <= {pwdata[6], pwdata[4], pwdata[3]};
            end
            if (paddr == `CCT_OFS_CH1_CTRL) begin
                en_r[2] <= pwdata[6];
            end
        end else if (done_w && paddr == `CCT_OFS_COUNT) begin
            cnt_r <= prdata[15:0];
            seen_r <= halt_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("access phase not answered after one wait state");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready && psel)
        else $error("error response outside a transfer");
    chk_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    chk_link_release: assert property (link_r && !busy0 |-> !chan_pin_oe[1])
        else $error("channel 1 pin still driven while linked");
    chk_cmp_drive: assert property ((m0_r || link_r) && !busy0 |-> chan_pin_oe[0])
        else $error("compare channel 0 pin not driven");
    chk_irq_quiet: assert property (!(|en_r) && !(|$past(en_r)) && !(psel && pwrite) |-> !irq)
        else $error("interrupt with every enable clear");
    chk_halt_hold: assert property (done_w && !pwrite && paddr == `CCT_OFS_COUNT && seen_r
        |-> prdata[15:0] == cnt_r)
        else $error("counter moved while halted");

    cover property (irq);
    cover property (link_r && !chan_pin_oe[1]);
    cover property (done_w && pslverr);
endmodule

bind cct_timer cct_timer_monitor #(.CW(CW)) u_cct_timer_monitor (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .chan_pin_oe, .irq);

`default_nettype wire

// *** testbench/tb.sv ***
`include "cct_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq, err;
    logic [1:0] pin_in, pin_out, pin_oe;
    logic [1:0] want = 2'b00;
    logic [15:0] c, c2;
    int failures = 0;
    int n_tests = 0;

    always #2 pclk = ~pclk;

    cct_timer u_cct_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan_pin_in(pin_in), .chan_pin_out(pin_out),
        .chan_pin_oe(pin_oe), .irq(irq));
    cct_pin_model u_pins (.pclk(pclk), .want(want), .oe(pin_oe), .drv(pin_out), .pin(pin_in));

    ////////////////////////////////////////////////////////////////////////////////
    // Checking and closing
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // APB master: request held until ready is sampled, bounded wait
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        {rd, err} = {prdata, pslverr};
        if (t >= 20) failures++;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog, well past the roughly 350 cycles the tests need
    initial begin
        #100000;
        failures++;
        test_done;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Tests
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`CCT_OFS_CTRL, 32'h20);
        rdc(`CCT_OFS_MODULO, 32'hffff);
        rdc(`CCT_OFS_CH1_CTRL, 32'h0);
        bus(1'b0, 12'h01c, 32'h0);
        chk(32'(err), 32'h1);
        $display("end of reset test");
        // A read every four cycles sees 4 >> ps ticks
        for (int ps = 0; ps < 3; ps++) begin
            bus(1'b1, `CCT_OFS_CTRL, 32'(ps));
            bus(1'b0, `CCT_OFS_COUNT, 32'h0);
            c = rd[15:0];
            bus(1'b0, `CCT_OFS_COUNT, 32'h0);
            chk(32'(rd[15:0] - c), 32'(4 >> ps));
        end
        bus(1'b1, `CCT_OFS_MODULO, 32'h7);
        bus(1'b1, `CCT_OFS_CTRL, 32'h10);
        repeat (20) @(posedge pclk);
        bus(1'b0, `CCT_OFS_CTRL, 32'h0);
        chk(32'(rd[7]), 32'h1);
        bus(1'b0, `CCT_OFS_COUNT, 32'h0);
        chk(32'(rd[15:0] <= 16'h7), 32'h1);
        bus(1'b1, `CCT_OFS_CTRL, 32'h20);
        bus(1'b0, `CCT_OFS_COUNT, 32'h0);
        rdc(`CCT_OFS_COUNT, 32'(rd[15:0]));
        bus(1'b1, `CCT_OFS_CTRL, 32'h07);
        bus(1'b0, `CCT_OFS_COUNT, 32'h0);
        rdc(`CCT_OFS_COUNT, 32'(rd[15:0]));
        bus(1'b1, `CCT_OFS_CTRL, 32'h30);
        rdc(`CCT_OFS_COUNT, 32'h0);
        $display("end of counter test");
        // Capture on a halted counter, so the latched value is known
        bus(1'b1, `CCT_OFS_CTRL, 32'h00);
        bus(1'b1, `CCT_OFS_CTRL, 32'h20);
        bus(1'b0, `CCT_OFS_COUNT, 32'h0);
        c = rd[15:0];
        bus(1'b1, `CCT_OFS_CH0_CTRL, 32'h01);
        want <= 2'b01;
        repeat (8) @(posedge pclk);
        rdc(`CCT_OFS_CH0_VAL, 32'(c));
        bus(1'b0, `CCT_OFS_CH0_CTRL, 32'h0);
        chk(32'(rd[7]), 32'h1);
        bus(1'b1, `CCT_OFS_CH0_CTRL, 32'hc1);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h1);
        bus(1'b1, `CCT_OFS_CTRL, 32'h00);
        bus(1'b1, `CCT_OFS_CTRL, 32'h20);
        bus(1'b0, `CCT_OFS_COUNT, 32'h0);
        c2 = rd[15:0];
        want <= 2'b00;
        repeat (8) @(posedge pclk);
        rdc(`CCT_OFS_CH0_VAL, 32'(c));
        bus(1'b1, `CCT_OFS_CH0_CTRL, 32'hc3);
        want <= 2'b01;
        repeat (8) @(posedge pclk);
        rdc(`CCT_OFS_CH0_VAL, 32'(c2));
        bus(1'b1, `CCT_OFS_CH0_CTRL, 32'h43);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h0);
        // Mid-run reset must keep the captured time
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`CCT_OFS_CH0_VAL, 32'(c2));
        rdc(`CCT_OFS_CTRL, 32'h20);
        $display("end of capture test");
        // Channel 1 compares while channel 0 sits at its reset control, no edge selected
        // Compare values written while the counter is stopped, so no match is lost
        bus(1'b1, `CCT_OFS_MODULO, 32'hf);
        bus(1'b1, `CCT_OFS_CH1_VAL, 32'h5);
        bus(1'b1, `CCT_OFS_CH1_CTRL, 32'h0b);
        bus(1'b1, `CCT_OFS_CTRL, 32'h10);
        repeat (40) @(posedge pclk);
        chk(32'({pin_oe[1], pin_out[1]}), 32'h3);
        rdc(`CCT_OFS_CH1_CTRL, 32'h8b);
        bus(1'b1, `CCT_OFS_CH1_CTRL, 32'h0a);
        repeat (40) @(posedge pclk);
        chk(32'(pin_out[1]), 32'h0);
        // Linking frees pin 1 and ignores channel 1 control
        bus(1'b1, `CCT_OFS_CH0_CTRL, 32'h18);
        bus(1'b1, `CCT_OFS_CH1_CTRL, 32'h0b);
        repeat (2) @(posedge pclk);
        chk(32'(pin_oe), 32'h1);
        // Pair 0 is active, so only the idle pair 1 is rewritten
        bus(1'b1, `CCT_OFS_CH1_VAL, 32'h3);
        rdc(`CCT_OFS_CH1_VAL, 32'h3);
        $display("end of compare test");
        test_done;
    end
endmodule

`default_nettype wire
